// *** verilog/wdrc_params.svh ***
// constants of the watchdog and reset-cause block
`ifndef WDRC_PARAMS_SVH
`define WDRC_PARAMS_SVH

// register byte offsets
`define WDRC_OFF_CAUSE      8'h00
`define WDRC_OFF_CTRL       8'h04
`define WDRC_OFF_IRQ_STAT   8'h08
`define WDRC_OFF_IRQ_MASK   8'h0c
`define WDRC_OFF_COUNT      8'h10

// reset cause field positions
`define WDRC_CAUSE_PWR      0
`define WDRC_CAUSE_PIN      1
`define WDRC_CAUSE_BOD      2
`define WDRC_CAUSE_WDT      3

// watchdog control field positions
`define WDRC_CTRL_SEL_LO    0
`define WDRC_CTRL_SEL_HI    2
`define WDRC_CTRL_EN        3
`define WDRC_CTRL_CE        4

// interrupt status field positions
`define WDRC_IRQ_TIMEOUT    0
`define WDRC_IRQ_BAD_OFF    1
`define WDRC_IRQ_BAD_SEL    2

// reset values
`define WDRC_CAUSE_RESET    4'h1
`define WDRC_CTRL_RESET     8'h00
`define WDRC_IRQ_RESET      3'h0

// timing
`define WDRC_CHG_CYCLES     3'h4
`define WDRC_TIMEOUT_BASE   16384
`define WDRC_OSC_FREQ_KHZ   1000

`endif

// *** verilog/wdrc_pkg.sv ***
// types shared by the watchdog and reset-cause modules
package wdrc_pkg;

    // state of the timeout counter
    typedef struct packed {
        logic        oscPrev;
        logic [22:0] count;
        logic        expired;
    } wdrc_cnt_s;

    // state of the register and bus logic
    typedef struct packed {
        logic        changeEn;
        logic        wdtEn;
        logic [2:0]  timeoutSel;
        logic [2:0]  chgCnt;
        logic [2:0]  irqMask;
        logic        wrPend;
        logic [7:0]  wrAddr;
        logic [31:0] rdata;
        logic        readyOut;
        logic        irqOut;
        logic        timeoutPulse;
        logic        wdtEnOut;
    } wdrc_main_s;

endpackage : wdrc_pkg

// *** verilog/wdrc_cnt_if.sv ***
// link between register logic and timeout counter
`timescale 1ns/100ps
interface wdrc_cnt_if;
    logic        clear;
    logic        enable;
    logic [2:0]  sel;
    logic        expired;
    logic [22:0] count;

    modport ctrl (output clear, output enable, output sel, input expired, input count);
    modport cnt  (input clear, input enable, input sel, output expired, output count);
endinterface : wdrc_cnt_if

// *** verilog/wdrc_sticky_flags.sv ***
// sticky flag bank, hardware set wins over software clear
`timescale 1ns/100ps
module wdrc_sticky_flags #(
    parameter int            W         = 3,
    parameter logic [W-1:0]  RESET_VAL = '0
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] setIn,
    input  wire logic [W-1:0] clrIn,
    output logic      [W-1:0] flags
);
    typedef struct packed {
        logic [W-1:0] flags;
    } wdrc_flags_s;

    wdrc_flags_s st_reg;
    wdrc_flags_s st_next;

    // a set in the clearing cycle is kept
    always_comb begin
        st_next.flags = (st_reg.flags & ~clrIn) | setIn;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_reg.flags <= RESET_VAL;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flags = st_reg.flags;
endmodule : wdrc_sticky_flags

// *** verilog/wdrc_timeout_counter.sv ***
// watchdog timeout counter stepped by oscillator edges
`timescale 1ns/100ps
`include "wdrc_params.svh"
module wdrc_timeout_counter
    import wdrc_pkg::*;
#(
    parameter int TIMEOUT_BASE = `WDRC_TIMEOUT_BASE
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic oscIn,
    wdrc_cnt_if.cnt   cif
);
    wdrc_cnt_s   st_reg;
    wdrc_cnt_s   st_next;
    logic        oscTick;
    logic [22:0] limit;

    // oscillator is slow and synchronous, so an edge detect is enough
    always_comb begin
        oscTick = oscIn & ~st_reg.oscPrev;
        limit   = 23'(TIMEOUT_BASE) << cif.sel;
        st_next = st_reg;
        st_next.oscPrev = oscIn;
        st_next.expired = 1'b0;
        if (cif.clear || !cif.enable) begin
            st_next.count = '0;
        end else if (oscTick) begin
            if (st_reg.count + 23'h1 >= limit) begin
                st_next.expired = 1'b1;
                st_next.count   = '0;
            end else begin
                st_next.count = st_reg.count + 23'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cif.expired = st_reg.expired;
    assign cif.count   = st_reg.count;
endmodule : wdrc_timeout_counter

// *** verilog/wdrc_watchdog.sv ***
// watchdog control, reset-cause flags and AHB-Lite register slave
//
// Overview of operation
// - bits 7 to 4 of the reset cause register always read as zero.
// - the watchdog timeout flag sets on a timeout reset and clears on power-on or a written zero.
// - the brown-out flag sets on a brown-out reset and clears on power-on or a written zero.
// - the pin reset flag sets on an external reset and clears on power-on or a written zero.
// - the power-on flag sets on power-on and only a written zero clears it.
// - the change-enable bit, once written to one, clears itself four clock cycles later.
// - writing one to enable turns the watchdog on; writing zero turns it off only while change-enable is set.
// - the timeout select changes only while change-enable is set at the moment of the write.
// - select code n gives a timeout of 16384 oscillator cycles shifted left by n.
// - bits 7 to 5 of the control register read as zero and the whole register resets to zero; with the always-on fuse the enable bit reads one.
// - the counter steps on the separate watchdog oscillator, not on the system clock.
// - restart, disable and any chip reset clear the counter.
// - a timeout yields an internal reset pulse of one system clock cycle.
// - with the always-on fuse the watchdog stays enabled and the enable bit reads one.
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "wdrc_params.svh"
module wdrc_watchdog
    import wdrc_pkg::*;
#(
    parameter int TIMEOUT_BASE = `WDRC_TIMEOUT_BASE
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // watchdog side
    input  wire logic        wdtOscIn,
    input  wire logic        restartInstruction,
    input  wire logic        alwaysOnFuse,
    input  wire logic        pinResetEvent,
    input  wire logic        brownoutEvent,
    output logic             timeoutReset,
    output logic             wdtEnabled,
    output logic             irq
);
    wdrc_main_s  st_reg;
    wdrc_main_s  st_next;
    wdrc_cnt_if  cif ();

    logic        addrPhase;
    logic        wrCause;
    logic        wrCtrl;
    logic        wrIrqStat;
    logic        wrIrqMask;
    logic        chipReset;
    logic        effEn;
    logic        badOff;
    logic        badSel;
    logic [3:0]  causeFlags;
    logic [3:0]  causeSet;
    logic [3:0]  causeClr;
    logic [2:0]  irqFlags;
    logic [2:0]  irqSet;
    logic [2:0]  irqClr;
    logic [7:0]  causeRead;
    logic [7:0]  ctrlRead;
    logic [2:0]  wrSel;
    logic        wrEn;
    logic        wrCe;

    // bus decode; only whole-word single transfers are expected
    always_comb begin
        addrPhase = hsel & htrans[1] & hready;
        wrCause   = st_reg.wrPend & (st_reg.wrAddr == `WDRC_OFF_CAUSE);
        wrCtrl    = st_reg.wrPend & (st_reg.wrAddr == `WDRC_OFF_CTRL);
        wrIrqStat = st_reg.wrPend & (st_reg.wrAddr == `WDRC_OFF_IRQ_STAT);
        wrIrqMask = st_reg.wrPend & (st_reg.wrAddr == `WDRC_OFF_IRQ_MASK);
        wrSel     = hwdata[`WDRC_CTRL_SEL_HI:`WDRC_CTRL_SEL_LO];
        wrEn      = hwdata[`WDRC_CTRL_EN];
        wrCe      = hwdata[`WDRC_CTRL_CE];
    end

    // timeout, pin and brown-out events each reset the chip logic
    always_comb begin
        chipReset = st_reg.timeoutPulse | pinResetEvent | brownoutEvent;
        effEn     = st_reg.wdtEn | alwaysOnFuse;
    end

    // refused writes: disable without change-enable, select change without it
    always_comb begin
        badOff = wrCtrl & ~wrEn & effEn & ~st_reg.changeEn & ~alwaysOnFuse;
        badSel = wrCtrl & ~st_reg.changeEn & (wrSel != st_reg.timeoutSel);
    end

    // reset cause flag events and clears
    always_comb begin
        causeSet = '0;
        causeSet[`WDRC_CAUSE_WDT] = st_reg.timeoutPulse;
        causeSet[`WDRC_CAUSE_BOD] = brownoutEvent;
        causeSet[`WDRC_CAUSE_PIN] = pinResetEvent;
        // a written zero clears, a written one leaves the flag
        causeClr = wrCause ? ~hwdata[3:0] : 4'h0;
    end

    // power-on (reset_n) loads only the power-on flag
    wdrc_sticky_flags #(
        .W         (4),
        .RESET_VAL (`WDRC_CAUSE_RESET)
    ) u_cause (
        .mclk    (mclk),
        .reset_n (reset_n),
        .setIn   (causeSet),
        .clrIn   (causeClr),
        .flags   (causeFlags)
    );

    // interrupt events, cleared by writing one
    always_comb begin
        irqSet = '0;
        irqSet[`WDRC_IRQ_TIMEOUT] = st_reg.timeoutPulse;
        irqSet[`WDRC_IRQ_BAD_OFF] = badOff;
        irqSet[`WDRC_IRQ_BAD_SEL] = badSel;
        irqClr = wrIrqStat ? hwdata[2:0] : 3'h0;
    end

    wdrc_sticky_flags #(
        .W         (3),
        .RESET_VAL (`WDRC_IRQ_RESET)
    ) u_irq (
        .mclk    (mclk),
        .reset_n (reset_n),
        .setIn   (irqSet),
        .clrIn   (irqClr),
        .flags   (irqFlags)
    );

    // counter hookup
    always_comb begin
        cif.clear  = restartInstruction | chipReset;
        cif.enable = effEn;
        cif.sel    = st_reg.timeoutSel;
    end

    wdrc_timeout_counter #(
        .TIMEOUT_BASE (TIMEOUT_BASE)
    ) u_counter (
        .mclk    (mclk),
        .reset_n (reset_n),
        .oscIn   (wdtOscIn),
        .cif     (cif)
    );

    // read images with reserved bits forced low
    always_comb begin
        causeRead = {4'h0, causeFlags};
        ctrlRead  = {3'h0, st_reg.changeEn, effEn, st_reg.timeoutSel};
    end

    // next state of control, bus and outputs
    always_comb begin
        st_next = st_reg;
        st_next.readyOut     = 1'b1;
        st_next.timeoutPulse = cif.expired;
        st_next.irqOut       = |(irqFlags & st_reg.irqMask);
        st_next.wdtEnOut     = effEn;

        // change window runs down on its own
        if (st_reg.changeEn) begin
            if (st_reg.chgCnt == 3'h1) begin
                st_next.changeEn = 1'b0;
                st_next.chgCnt   = 3'h0;
            end else begin
                st_next.chgCnt = st_reg.chgCnt - 3'h1;
            end
        end

        // control write; the window is judged by its value before the write
        if (wrCtrl) begin
            if (wrEn) begin
                st_next.wdtEn = 1'b1;
            end else if (st_reg.changeEn) begin
                st_next.wdtEn = 1'b0;
            end
            if (st_reg.changeEn) begin
                st_next.timeoutSel = wrSel;
            end
            if (wrCe) begin
                st_next.changeEn = 1'b1;
                st_next.chgCnt   = `WDRC_CHG_CYCLES;
            end else begin
                // closing the window by hand is allowed
                st_next.changeEn = 1'b0;
                st_next.chgCnt   = 3'h0;
            end
        end

        if (wrIrqMask) begin
            st_next.irqMask = hwdata[2:0];
        end

        // chip reset wins over a control write in the same cycle
        if (chipReset) begin
            st_next.changeEn   = 1'b0;
            st_next.wdtEn      = 1'b0;
            st_next.timeoutSel = 3'h0;
            st_next.chgCnt     = 3'h0;
        end

        // address phase: latch write target, fetch read data early
        st_next.wrPend = addrPhase & hwrite;
        if (addrPhase) begin
            st_next.wrAddr = haddr[7:0];
        end
        if (addrPhase && !hwrite) begin
            unique case (haddr[7:0])
                `WDRC_OFF_CAUSE:    st_next.rdata = {24'h0, causeRead};
                `WDRC_OFF_CTRL:     st_next.rdata = {24'h0, ctrlRead};
                `WDRC_OFF_IRQ_STAT: st_next.rdata = {29'h0, irqFlags};
                `WDRC_OFF_IRQ_MASK: st_next.rdata = {29'h0, st_reg.irqMask};
                `WDRC_OFF_COUNT:    st_next.rdata = {9'h0, cif.count};
                default:            st_next.rdata = 32'h0;
            endcase
        end
    end

    // the one register bank
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_reg          <= '0;
            st_reg.readyOut <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // all outputs but hresp come straight from flops; hresp is tied low
    assign hreadyout    = st_reg.readyOut;
    assign hresp        = 1'b0;
    assign hrdata       = st_reg.rdata;
    assign timeoutReset = st_reg.timeoutPulse;
    assign wdtEnabled   = st_reg.wdtEnOut;
    assign irq          = st_reg.irqOut;
endmodule : wdrc_watchdog

// *** tb/wdrc_watchdog_monitor.sv ***
// concurrent checks on the watchdog block ports
`timescale 1ns/100ps
`include "wdrc_params.svh"
module wdrc_watchdog_monitor (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        restartInstruction,
    input wire logic        alwaysOnFuse,
    input wire logic        timeoutReset,
    input wire logic        wdtEnabled
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // read address phases of the two documented registers
    sequence readCause;
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] == `WDRC_OFF_CAUSE;
    endsequence
    sequence readCtrl;
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] == `WDRC_OFF_CTRL;
    endsequence

    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
    a_cause_rsvd_zero: assert property (readCause |=> hrdata[31:4] == 28'h0)
        else $error("cause reserved bits set");
    a_ctrl_rsvd_zero: assert property (readCtrl |=> hrdata[31:5] == 27'h0)
        else $error("control reserved bits set");
    a_fuse_reads_on: assert property (alwaysOnFuse[*2] ##0 readCtrl |=> hrdata[3])
        else $error("enable bit reads zero under fuse");
    a_fuse_keeps_on: assert property (alwaysOnFuse[*3] |-> wdtEnabled)
        else $error("watchdog off under fuse");
    a_pulse_one_cycle: assert property (timeoutReset |=> !timeoutReset)
        else $error("timeout pulse longer than one cycle");
    a_restart_blocks: assert property (restartInstruction[*4] |-> !timeoutReset)
        else $error("timeout while restart held");
    a_timeout_enabled: assert property (timeoutReset |-> $past(wdtEnabled))
        else $error("timeout while disabled");
    a_disabled_quiet: assert property (!wdtEnabled[*4] |-> !timeoutReset)
        else $error("disabled watchdog timed out");
endmodule : wdrc_watchdog_monitor

bind wdrc_watchdog wdrc_watchdog_monitor mon_u (
    .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .restartInstruction(restartInstruction), .alwaysOnFuse(alwaysOnFuse),
    .timeoutReset(timeoutReset), .wdtEnabled(wdtEnabled));

// *** tb/wdrc_watchdog_tb.sv ***
// self-checking bench for the watchdog and reset-cause block
`timescale 1ns/100ps
`include "wdrc_params.svh"
module wdrc_watchdog_tb;
    logic        mclk = 0, reset_n = 0, hsel = 0, hwrite = 0, wdtOscIn = 0;
    logic        restartInstruction = 1, alwaysOnFuse = 0, pinResetEvent = 0, brownoutEvent = 0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic        hreadyout, hresp, timeoutReset, wdtEnabled, irq, oscSeen;
    logic [3:0]  oscDiv = 4'h0;
    int          err_count = 0, samples_checked = 0, rises;

    always #2.5 mclk = ~mclk;

    // slow oscillator stand-in, 20 system cycles a period
    always @(posedge mclk) begin
        oscDiv <= (oscDiv == 4'h9) ? 4'h0 : oscDiv + 4'h1;
        if (oscDiv == 4'h9) begin
            wdtOscIn <= ~wdtOscIn;
        end
    end

    // short base keeps the timeout run brief
    wdrc_watchdog #(.TIMEOUT_BASE(4)) dut_u (
        .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .wdtOscIn(wdtOscIn), .restartInstruction(restartInstruction),
        .alwaysOnFuse(alwaysOnFuse), .pinResetEvent(pinResetEvent), .brownoutEvent(brownoutEvent),
        .timeoutReset(timeoutReset), .wdtEnabled(wdtEnabled), .irq(irq));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("mismatches %0d of %0d checks", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    // one single ahb-lite transfer, entered right after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask : rd

    task automatic por;
        reset_n <= 1'b0;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
    endtask : por

    // cut a hang short; the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        close_out();
    end

    initial begin
        por();
        chk(hresp, 0);
        rd(`WDRC_OFF_CAUSE, 32'h01);
        rd(`WDRC_OFF_CTRL, 32'h00);
        rd(8'h20, 32'h0);
        // open the window, then watch it close by itself
        wr(`WDRC_OFF_CTRL, 32'hf8);
        rd(`WDRC_OFF_CTRL, 32'h18);
        repeat (4) @(posedge mclk);
        rd(`WDRC_OFF_CTRL, 32'h08);
        chk(wdtEnabled, 1);
        // timed disable inside the window
        wr(`WDRC_OFF_CTRL, 32'h18);
        wr(`WDRC_OFF_CTRL, 32'h00);
        rd(`WDRC_OFF_CTRL, 32'h00);
        chk(wdtEnabled, 0);
        // refused disable and refused select change with the window shut
        wr(`WDRC_OFF_CTRL, 32'h08);
        wr(`WDRC_OFF_CTRL, 32'h00);
        wr(`WDRC_OFF_CTRL, 32'h0b);
        rd(`WDRC_OFF_CTRL, 32'h08);
        rd(`WDRC_OFF_IRQ_STAT, 32'h06);
        chk(irq, 0);
        wr(`WDRC_OFF_IRQ_MASK, 32'h06);
        repeat (2) @(posedge mclk);
        chk(irq, 1);
        wr(`WDRC_OFF_IRQ_STAT, 32'h06);
        repeat (2) @(posedge mclk);
        chk(irq, 0);
        // select code 1 gives twice the base, counted from restart release
        wr(`WDRC_OFF_CTRL, 32'h18);
        wr(`WDRC_OFF_CTRL, 32'h09);
        rd(`WDRC_OFF_CTRL, 32'h09);
        @(posedge wdtOscIn);
        @(posedge mclk);
        restartInstruction <= 1'b0;
        oscSeen = 1'b1;
        rises = 0;
        for (int n = 0; n < 2000 && timeoutReset !== 1'b1; n++) begin
            @(posedge mclk);
            if (wdtOscIn && !oscSeen) rises++;
            oscSeen = wdtOscIn;
        end
        chk(rises, 8);
        chk(timeoutReset, 1);
        @(posedge mclk);
        chk(timeoutReset, 0);
        restartInstruction <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(`WDRC_OFF_CAUSE, 32'h09);
        rd(`WDRC_OFF_CTRL, 32'h00);
        // chip reset sources set their flags
        pinResetEvent <= 1'b1;
        @(posedge mclk);
        pinResetEvent <= 1'b0;
        brownoutEvent <= 1'b1;
        @(posedge mclk);
        brownoutEvent <= 1'b0;
        rd(`WDRC_OFF_CAUSE, 32'h0f);
        wr(`WDRC_OFF_CAUSE, 32'hf7);
        rd(`WDRC_OFF_CAUSE, 32'h07);
        wr(`WDRC_OFF_CAUSE, 32'hfe);
        rd(`WDRC_OFF_CAUSE, 32'h06);
        por();
        rd(`WDRC_OFF_CAUSE, 32'h01);
        // fuse keeps the watchdog on against a plain clear
        alwaysOnFuse <= 1'b1;
        repeat (3) @(posedge mclk);
        wr(`WDRC_OFF_CTRL, 32'h00);
        rd(`WDRC_OFF_CTRL, 32'h08);
        chk(wdtEnabled, 1);
        close_out();
    end
endmodule : wdrc_watchdog_tb
